/* hw/rcdrst_device.sv */
// Overview of operation
// - Reset low disables receivers; floating inputs tolerated.
// - Reset low restores control registers to defaults.
// - Reset drives clock-enables low, floats other outputs.
// - Reset keeps low power, no input termination.
// - Host: stable vref, clock, selects high first.
// - Host: clock-enable inputs low for stabilization.
// - No forwarding until reset over and stabilized.
// - Host keeps reset at a valid level.
// - Start in reset; leave only with stable clock.
// - Reset entry asynchronous; outputs float at once.
// - Host holds reset 200 us after power.
// - Chip-select top index follows four-select strap.
// - Parity error pin released high during reset.
// - Termination outputs low, then follow inputs.
// - Host: soft reset lasts at least 100 ns.
`timescale 1ns/1ps
module rcdrst_device #(
    parameter int unsigned STAB_WAIT = rcdrst_pkg::STAB_CYCLES
) (
    input  wire logic                       clk_i,
    input  wire logic                       four_select_mode_i,
    input  wire logic [7:0]                 ctrl_wdata_i,
    input  wire logic                       ctrl_we_i,
    output logic      [7:0]                 ctrl_o,
    output logic                            ready_o,
    output logic      [1:0]                 cs_max_idx_o,
    output logic                            receivers_on_o,
    output logic                            termination_on_o,
    rcdrst_if.device                        link
);
    import rcdrst_pkg::*;

    initial begin
        if (STAB_WAIT < 1 || STAB_WAIT > 32'h00FF_FFFF) begin
            $error("rcdrst_device: STAB_WAIT out of range");
        end
    end

    logic [SYNC_STAGES-1:0] sync_reg;
    logic                   rst_sync_n;
    rcdrst_state_e          state_reg;
    rcdrst_state_e          state_next;
    logic [23:0]            cnt_reg;
    logic [23:0]            cnt_next;
    logic [7:0]             ctrl_reg;
    logic [7:0]             ctrl_next;
    logic                   quad_reg;
    logic                   quad_next;
    logic                   odt_follow_reg;
    logic                   odt_follow_next;
    logic [ODT_WIDTH-1:0]   odt_reg;
    logic [ODT_WIDTH-1:0]   odt_next;
    logic [CS_WIDTH-1:0]    cs_reg;
    logic [CS_WIDTH-1:0]    cs_next;
    logic [CA_WIDTH-1:0]    ca_reg;
    logic [CA_WIDTH-1:0]    ca_next;
    logic [3:0]             cke_reg;
    logic [3:0]             cke_next;
    logic [CS_WIDTH-1:0]    cs_mask;
    logic                   one_cs_low;
    logic                   running;

    // Release passes a shift chain; assertion clears it at once.
    always_ff @(posedge clk_i or negedge link.reset_n) begin
        if (!link.reset_n) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= {sync_reg[SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign rst_sync_n = sync_reg[SYNC_STAGES-1];

    assign running = (state_reg == RCDRST_RUN);

    // Only the selects that exist in the current mode take part.
    always_comb begin
        cs_mask = quad_reg ? 4'hF : 4'h3;
        cs_max_idx_o = quad_reg ? CS_MAX_IDX_QUAD[1:0]
                                : CS_MAX_IDX_DUAL[1:0];
        one_cs_low = $countones(~link.chip_select_inputs & cs_mask) == 1;
    end

    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_reg;
        ctrl_next       = ctrl_reg;
        quad_next       = quad_reg;
        odt_follow_next = odt_follow_reg;
        odt_next        = odt_reg;
        cs_next         = cs_reg;
        ca_next         = ca_reg;
        cke_next        = cke_reg;
        unique case (state_reg)
            RCDRST_RESET: begin
                // Leaving reset needs a stable clock present.
                if (rst_sync_n && link.clk_stable) begin
                    state_next = RCDRST_STAB;
                    cnt_next   = 24'h000000;
                    quad_next  = four_select_mode_i;
                end
            end
            RCDRST_STAB: begin
                odt_follow_next = 1'b1;
                odt_next = odt_follow_reg ? link.termination_control_inputs
                                          : '0;
                if (cnt_reg == 24'(STAB_WAIT - 1)) begin
                    state_next = RCDRST_RUN;
                end else begin
                    cnt_next = cnt_reg + 24'h000001;
                end
            end
            RCDRST_RUN: begin
                odt_next = link.termination_control_inputs;
                if (ctrl_we_i) begin
                    ctrl_next = ctrl_wdata_i;
                end
                cke_next = {link.clock_enable_input_1,
                            link.clock_enable_input_0,
                            link.clock_enable_input_1,
                            link.clock_enable_input_0};
                if (one_cs_low) begin
                    cs_next = link.chip_select_inputs | ~cs_mask;
                    ca_next = link.ca_in;
                end else begin
                    cs_next = '1;
                end
            end
        endcase
    end

    // Asynchronous entry restores every register to its default.
    always_ff @(posedge clk_i or negedge link.reset_n) begin
        if (!link.reset_n) begin
            state_reg      <= RCDRST_RESET;
            cnt_reg        <= 24'h000000;
            ctrl_reg       <= CTRL_DEFAULT;
            quad_reg       <= 1'b0;
            odt_follow_reg <= 1'b0;
            odt_reg        <= '0;
            cs_reg         <= '1;
            ca_reg         <= '0;
            cke_reg        <= 4'h0;
        end else begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            ctrl_reg       <= ctrl_next;
            quad_reg       <= quad_next;
            odt_follow_reg <= odt_follow_next;
            odt_reg        <= odt_next;
            cs_reg         <= cs_next;
            ca_reg         <= ca_next;
            cke_reg        <= cke_next;
        end
    end

    // Enables gate on the raw reset so outputs float without a clock.
    always_comb begin
        ctrl_o           = ctrl_reg;
        ready_o          = running;
        receivers_on_o   = link.reset_n && rst_sync_n;
        termination_on_o = link.reset_n && rst_sync_n;
        link.side_a_mem_clock_enable_out_0 =
            link.reset_n & cke_reg[0];
        link.side_a_mem_clock_enable_out_1 = link.reset_n & cke_reg[1];
        link.side_b_mem_clock_enable_out_0 = link.reset_n & cke_reg[2];
        link.side_b_mem_clock_enable_out_1 = link.reset_n & cke_reg[3];
        link.termination_control_outputs    = odt_reg;
        link.termination_control_outputs_oe =
            {ODT_WIDTH{link.reset_n && state_reg != RCDRST_RESET}};
        link.cs_out    = cs_reg;
        link.cs_out_oe = link.reset_n && state_reg != RCDRST_RESET;
        link.ca_out    = ca_reg;
        link.ca_out_oe = link.reset_n && running;
        // Open-drain error pin released: reads high through its pull-up.
        link.parity_error_flag_out_oe = 1'b0;
    end
endmodule

/* hw/rcdrst_host.sv */
`timescale 1ns/1ps
module rcdrst_host #(
    parameter int unsigned PWR_WAIT  = rcdrst_pkg::PWR_RESET_CYCLES,
    parameter int unsigned STAB_WAIT = rcdrst_pkg::STAB_CYCLES
) (
    input  wire logic                             clk_i,
    input  wire logic                             rst_n_i,
    input  wire logic                             soft_reset_i,
    input  wire logic                             clk_ok_i,
    input  wire logic                             vref_ok_i,
    input  wire logic [rcdrst_pkg::CS_WIDTH-1:0]  cmd_cs_i,
    input  wire logic                             cmd_cke0_i,
    input  wire logic                             cmd_cke1_i,
    input  wire logic [rcdrst_pkg::ODT_WIDTH-1:0] cmd_odt_i,
    input  wire logic [rcdrst_pkg::CA_WIDTH-1:0]  cmd_ca_i,
    output logic                                  ready_o,
    rcdrst_if.host                                link
);
    import rcdrst_pkg::*;

    initial begin
        if (PWR_WAIT < SOFT_RESET_CYCLES || PWR_WAIT > 32'h00FF_FFFF ||
            STAB_WAIT < 1 || STAB_WAIT > 32'h00FF_FFFF) begin
            $error("rcdrst_host: wait parameters out of range");
        end
    end

    rcdrst_host_state_e state_reg;
    rcdrst_host_state_e state_next;
    logic [23:0]        cnt_reg;
    logic [23:0]        cnt_next;
    logic               first_reg;
    logic               first_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 24'h000001;
        first_next = first_reg;
        unique case (state_reg)
            RCDRST_H_RESET: begin
                // Power-on hold first, soft resets afterwards.
                if (cnt_reg >= 24'((first_reg ? PWR_WAIT
                                   : SOFT_RESET_CYCLES) - 1)
                    && clk_ok_i && vref_ok_i && !soft_reset_i) begin
                    state_next = RCDRST_H_LEAD;
                    cnt_next   = 24'h000000;
                    first_next = 1'b0;
                end
            end
            RCDRST_H_LEAD: begin
                if (cnt_reg == 24'(ACT_LEAD_CYCLES - 1)) begin
                    state_next = RCDRST_H_STAB;
                    cnt_next   = 24'h000000;
                end
            end
            RCDRST_H_STAB: begin
                if (cnt_reg == 24'(STAB_WAIT + SYNC_STAGES + 1)) begin
                    state_next = RCDRST_H_RUN;
                end
            end
            RCDRST_H_RUN: begin
                cnt_next = cnt_reg;
            end
        endcase
        if (soft_reset_i) begin
            state_next = RCDRST_H_RESET;
            cnt_next   = 24'h000000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= RCDRST_H_RESET;
            cnt_reg   <= 24'h000000;
            first_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            first_reg <= first_next;
        end
    end

    always_comb begin
        ready_o          = state_reg == RCDRST_H_RUN;
        // Reset stays low through the lead time and is never left floating.
        link.reset_n     = state_reg inside {RCDRST_H_STAB,
                                             RCDRST_H_RUN};
        link.clk_stable  = clk_ok_i;
        link.vref_stable = vref_ok_i;
        link.chip_select_inputs = ready_o ? cmd_cs_i : '1;
        link.clock_enable_input_0 = ready_o & cmd_cke0_i;
        link.clock_enable_input_1 = ready_o & cmd_cke1_i;
        link.termination_control_inputs = cmd_odt_i;
        link.ca_in = cmd_ca_i;
    end
endmodule

/* include/rcdrst_if.sv */
`timescale 1ns/1ps
interface rcdrst_if;
    import rcdrst_pkg::*;
    logic                    reset_n;
    logic                    clk_stable;
    logic                    vref_stable;
    logic [CS_WIDTH-1:0]     chip_select_inputs;
    logic                    clock_enable_input_0;
    logic                    clock_enable_input_1;
    logic [ODT_WIDTH-1:0]    termination_control_inputs;
    logic [CA_WIDTH-1:0]     ca_in;
    logic                    side_a_mem_clock_enable_out_0;
    logic                    side_a_mem_clock_enable_out_1;
    logic                    side_b_mem_clock_enable_out_0;
    logic                    side_b_mem_clock_enable_out_1;
    logic [ODT_WIDTH-1:0]    termination_control_outputs;
    logic [ODT_WIDTH-1:0]    termination_control_outputs_oe;
    logic [CS_WIDTH-1:0]     cs_out;
    logic                    cs_out_oe;
    logic [CA_WIDTH-1:0]     ca_out;
    logic                    ca_out_oe;
    logic                    parity_error_flag_out_oe;

    modport device (
        input  reset_n, clk_stable, vref_stable, chip_select_inputs,
               clock_enable_input_0, clock_enable_input_1,
               termination_control_inputs, ca_in,
        output side_a_mem_clock_enable_out_0, side_a_mem_clock_enable_out_1,
               side_b_mem_clock_enable_out_0, side_b_mem_clock_enable_out_1,
               termination_control_outputs, termination_control_outputs_oe,
               cs_out, cs_out_oe, ca_out, ca_out_oe,
               parity_error_flag_out_oe
    );
    modport host (
        output reset_n, clk_stable, vref_stable, chip_select_inputs,
               clock_enable_input_0, clock_enable_input_1,
               termination_control_inputs, ca_in,
        input  side_a_mem_clock_enable_out_0, side_a_mem_clock_enable_out_1,
               side_b_mem_clock_enable_out_0, side_b_mem_clock_enable_out_1,
               termination_control_outputs, termination_control_outputs_oe,
               cs_out, cs_out_oe, ca_out, ca_out_oe,
               parity_error_flag_out_oe
    );
endinterface

/* include/rcdrst_pkg.sv */
package rcdrst_pkg;
    // Clock period in picoseconds (40 MHz).
    localparam int unsigned CLK_PERIOD_PS   = 25000;
    // Longest PLL stabilization interval at the test band, in microseconds.
    localparam int unsigned STAB_TIME_US    = 15;
    // Cycles the device waits after reset release before forwarding.
    localparam int unsigned STAB_CYCLES     =
        (STAB_TIME_US * 1000000) / CLK_PERIOD_PS;
    // Power-on reset hold, microseconds, and its least cycle count.
    localparam int unsigned PWR_RESET_US    = 200;
    localparam int unsigned PWR_RESET_CYCLES =
        (PWR_RESET_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Soft reset hold, nanoseconds, and its least cycle count.
    localparam int unsigned SOFT_RESET_NS   = 100;
    localparam int unsigned SOFT_RESET_CYCLES =
        (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Activation lead time before reset release, cycles (plain default).
    localparam int unsigned ACT_LEAD_CYCLES = 4;
    // Depth of the reset release synchroniser.
    localparam int unsigned SYNC_STAGES     = 2;
    // Highest chip-select index per select mode.
    localparam int unsigned CS_MAX_IDX_DUAL = 1;
    localparam int unsigned CS_MAX_IDX_QUAD = 3;
    localparam int unsigned CS_WIDTH        = 4;
    localparam int unsigned CKE_IN_WIDTH    = 2;
    localparam int unsigned ODT_WIDTH       = 2;
    localparam int unsigned CA_WIDTH        = 22;
    // Control register defaults restored by reset.
    localparam logic [7:0]  CTRL_DEFAULT    = 8'h00;

    typedef enum logic [2:0] {
        RCDRST_RESET   = 3'b001,
        RCDRST_STAB    = 3'b010,
        RCDRST_RUN     = 3'b100
    } rcdrst_state_e;

    typedef enum logic [3:0] {
        RCDRST_H_RESET = 4'b0001,
        RCDRST_H_LEAD  = 4'b0010,
        RCDRST_H_STAB  = 4'b0100,
        RCDRST_H_RUN   = 4'b1000
    } rcdrst_host_state_e;
endpackage

/* testbench/rcd_reset_init_control_tb.sv */
`timescale 1ns/1ps
module rcd_reset_init_control_tb;
    import rcdrst_pkg::*;
    localparam int unsigned WAIT_N = 8;
    logic                 clk_i, rst_n_i, soft_reset_i, quad, we, clk_ok;
    logic [CS_WIDTH-1:0]  cmd_cs;
    logic [ODT_WIDTH-1:0] cmd_odt;
    logic [CA_WIDTH-1:0]  cmd_ca;
    logic [7:0]           wdata, ctrl_o;
    logic [1:0]           cs_max_idx_o;
    logic                 dev_ready, host_ready, rx_on, term_on;
    logic [3:0]           cke_q, oe_q;
    int                   miscompares, total_checks, cycles, n;
    rcdrst_if bus ();
    assign cke_q = {bus.side_b_mem_clock_enable_out_1,
        bus.side_b_mem_clock_enable_out_0, bus.side_a_mem_clock_enable_out_1,
        bus.side_a_mem_clock_enable_out_0};
    assign oe_q = {bus.cs_out_oe, bus.ca_out_oe,
        bus.termination_control_outputs_oe};
    rcdrst_device #(.STAB_WAIT(WAIT_N)) u_rcdrst_device (.clk_i(clk_i),
        .four_select_mode_i(quad), .ctrl_wdata_i(wdata), .ctrl_we_i(we),
        .ctrl_o(ctrl_o), .ready_o(dev_ready), .cs_max_idx_o(cs_max_idx_o),
        .receivers_on_o(rx_on), .termination_on_o(term_on), .link(bus));
    rcdrst_host #(.PWR_WAIT(WAIT_N), .STAB_WAIT(WAIT_N)) u_rcdrst_host (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i),
        .clk_ok_i(clk_ok), .vref_ok_i(1'b1), .cmd_cs_i(cmd_cs),
        .cmd_cke0_i(1'b1), .cmd_cke1_i(1'b0), .cmd_odt_i(cmd_odt),
        .cmd_ca_i(cmd_ca), .ready_o(host_ready), .link(bus));
    rcdrst_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .reset_n(bus.reset_n), .clk_stable(bus.clk_stable),
        .vref_stable(bus.vref_stable),
        .chip_select_inputs(bus.chip_select_inputs),
        .clock_enable_input_0(bus.clock_enable_input_0),
        .clock_enable_input_1(bus.clock_enable_input_1),
        .termination_control_inputs(bus.termination_control_inputs),
        .ca_in(bus.ca_in),
        .side_a_mem_clock_enable_out_0(bus.side_a_mem_clock_enable_out_0),
        .side_a_mem_clock_enable_out_1(bus.side_a_mem_clock_enable_out_1),
        .side_b_mem_clock_enable_out_0(bus.side_b_mem_clock_enable_out_0),
        .side_b_mem_clock_enable_out_1(bus.side_b_mem_clock_enable_out_1),
        .termination_control_outputs(bus.termination_control_outputs),
        .termination_control_outputs_oe(bus.termination_control_outputs_oe),
        .cs_out(bus.cs_out), .cs_out_oe(bus.cs_out_oe), .ca_out(bus.ca_out),
        .ca_out_oe(bus.ca_out_oe),
        .parity_error_flag_out_oe(bus.parity_error_flag_out_oe));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    // Checks the reset state, then counts cycles until reset lifts.
    task automatic check_reset_then_release;
        check({dev_ready, rx_on, term_on}, 3'h0);
        check(bus.reset_n, 1'b0);
        check(ctrl_o, CTRL_DEFAULT);
        check({cke_q, oe_q}, 8'h00);
        n = 0;
        while (bus.reset_n !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task automatic wait_ready;
        n = 0;
        while ((dev_ready & host_ready) !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        check(dev_ready & host_ready, 1'b1);
    endtask
    task automatic t_power_up;
        rst_n_i = 1'b1;
        check_reset_then_release();
        check(n >= WAIT_N + ACT_LEAD_CYCLES, 1'b1);
        wait_ready();
        check(n >= WAIT_N, 1'b1);
        check({rx_on, cs_max_idx_o}, {1'b1, 2'(CS_MAX_IDX_DUAL)});
    endtask
    task automatic send_cmd(input logic [3:0] cs, input logic [21:0] ca,
                            input logic [3:0] cs_exp,
                            input logic [21:0] ca_exp);
        cmd_cs = cs;
        cmd_ca = ca;
        n = 0;
        while (bus.chip_select_inputs !== cs && n < 10) begin
            @(negedge clk_i);
            n++;
        end
        repeat (2) @(negedge clk_i);
        check({bus.cs_out, bus.ca_out}, {cs_exp, ca_exp});
        check(cke_q, 4'h5);
    endtask
    task automatic t_soft_reset;
        wdata = 8'hA5;
        we = 1'b1;
        @(negedge clk_i);
        we = 1'b0;
        @(negedge clk_i);
        check(ctrl_o, 8'hA5);
        quad = 1'b1;
        soft_reset_i = 1'b1;
        repeat (3) @(negedge clk_i);
        soft_reset_i = 1'b0;
        check_reset_then_release();
        check(n >= SOFT_RESET_CYCLES + ACT_LEAD_CYCLES, 1'b1);
        wait_ready();
        check(cs_max_idx_o, 2'(CS_MAX_IDX_QUAD));
    endtask
    task automatic t_async;
        @(negedge clk_i);
        rst_n_i = 1'b0;
        #2;
        check({bus.reset_n, cke_q, oe_q}, 9'h000);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        clk_ok = 1'b0;
        repeat (20) @(negedge clk_i);
        check({bus.reset_n, dev_ready, rx_on}, 3'h0);
        clk_ok = 1'b1;
        wait_ready();
        check(dev_ready, 1'b1);
    endtask
    initial begin
        {rst_n_i, soft_reset_i, quad, we, wdata} = '0;
        clk_ok = 1'b1;
        {miscompares, total_checks, cycles} = '0;
        cmd_cs = 4'hF;
        cmd_odt = 2'h3;
        cmd_ca = '0;
        repeat (16) @(negedge clk_i);
        t_power_up();
        send_cmd(4'hE, 22'h2A5A5, 4'hE, 22'h2A5A5);
        send_cmd(4'hF, 22'h15A5A, 4'hF, 22'h2A5A5);
        send_cmd(4'h7, 22'h0F0F0, 4'hF, 22'h2A5A5);
        t_soft_reset();
        send_cmd(4'h7, 22'h0F0F0, 4'h7, 22'h0F0F0);
        t_async();
        summarize();
    end
endmodule

/* testbench/rcdrst_sva.sv */
`timescale 1ns/1ps
module rcdrst_sva
    import rcdrst_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 rst_n_i,
    input wire logic                 reset_n,
    input wire logic                 clk_stable,
    input wire logic                 vref_stable,
    input wire logic [CS_WIDTH-1:0]  chip_select_inputs,
    input wire logic                 clock_enable_input_0,
    input wire logic                 clock_enable_input_1,
    input wire logic [ODT_WIDTH-1:0] termination_control_inputs,
    input wire logic [CA_WIDTH-1:0]  ca_in,
    input wire logic                 side_a_mem_clock_enable_out_0,
    input wire logic                 side_a_mem_clock_enable_out_1,
    input wire logic                 side_b_mem_clock_enable_out_0,
    input wire logic                 side_b_mem_clock_enable_out_1,
    input wire logic [ODT_WIDTH-1:0] termination_control_outputs,
    input wire logic [ODT_WIDTH-1:0] termination_control_outputs_oe,
    input wire logic [CS_WIDTH-1:0]  cs_out,
    input wire logic                 cs_out_oe,
    input wire logic [CA_WIDTH-1:0]  ca_out,
    input wire logic                 ca_out_oe,
    input wire logic                 parity_error_flag_out_oe
);
    logic [3:0] cke_q;
    logic [3:0] cke_d;
    logic       run;
    assign cke_q = {side_b_mem_clock_enable_out_1,
        side_b_mem_clock_enable_out_0, side_a_mem_clock_enable_out_1,
        side_a_mem_clock_enable_out_0};
    assign cke_d = {clock_enable_input_1, clock_enable_input_0,
        clock_enable_input_1, clock_enable_input_0};
    assign run = ca_out_oe;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_cke_low_reset: assert property (
        !reset_n |-> cke_q == 4'h0) else $error("clock enable out high");
    a_float_reset: assert property (
        !reset_n |-> !cs_out_oe && !ca_out_oe &&
        termination_control_outputs_oe == 2'h0) else $error("driven in reset");
    a_err_released: assert property (
        parity_error_flag_out_oe == 1'b0) else $error("error pin driven");
    a_hold_fwd: assert property (
        $rose(reset_n) |-> !ca_out_oe [*8]) else $error("early forwarding");
    a_odt_release: assert property (
        $rose(cs_out_oe) |-> termination_control_outputs == 2'h0 ##2
        termination_control_outputs == $past(termination_control_inputs))
        else $error("termination out wrong after release");
    a_clk_for_exit: assert property (
        $rose(cs_out_oe) |-> $past(clk_stable)) else $error("left reset");
    a_cmd_fwd: assert property (
        run && $past(run) && $past(chip_select_inputs) inside {4'hE, 4'hD}
        |-> cs_out == $past(chip_select_inputs) && ca_out == $past(ca_in))
        else $error("command not forwarded");
    a_cs_idle: assert property (
        run && $past(run) && $past(chip_select_inputs) == 4'hF
        |-> cs_out == 4'hF && $stable(ca_out)) else $error("idle not kept");
    a_cke_map: assert property (
        run && $past(run) |-> cke_q == $past(cke_d)) else $error("cke map");
    a_host_release: assert property (
        $rose(reset_n) |-> $past(chip_select_inputs) == 4'hF &&
        $past(vref_stable) && $past(clk_stable)) else $error("bad release");
    a_cke_in_low: assert property (
        $rose(reset_n) |-> (!clock_enable_input_0 && !clock_enable_input_1)
        [*8]) else $error("clock enable input high too early");
    c_release: cover property ($rose(reset_n));
    c_run: cover property ($rose(ca_out_oe));
    c_cmd: cover property (run && cs_out == 4'hE);
endmodule
